// ==== line_global_pkg.sv ====
// Constants, types and register map of the line unit global control block
// Summary of operation
// - Gate low: no interrupt on the pin
// - Gate high: only enabled sources raise interrupt
// - Reset starts after bit held over 10 us
// - Soft reset spares software visible register bits
// - Transmit sync bit: all channels send sync waveform
// - Transmit sync bit overrides other transmit settings
// - Receive sync bit: recovery accepts sync waveform
// - Receive sync clear: equalizer field selects mode
// - All four global bits reset to zero
`default_nettype none
package line_global_pkg;
   // Sizes
   localparam int NUM_CH = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int EQ_W = 5;
   localparam int SHAPE_W = 3;
   localparam int CNT_W = 9;
   // Register offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL_A = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CTRL_B = 8'h01;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h02;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h03;
   localparam logic [ADDR_W-1:0] OFF_STATE = 8'h04;
   // Field positions
   localparam int BIT_SOFT_RESET = 0;
   localparam int BIT_IRQ_GATE = 1;
   localparam int BIT_RX_SYNC = 6;
   localparam int BIT_TX_SYNC = 7;
   localparam int BIT_RESET_ACTIVE = 0;
   localparam int BIT_HOLD_COUNTING = 1;
   // Writable bits and reset values
   localparam logic [DATA_W-1:0] CTRL_A_WMASK = 8'h03;
   localparam logic [DATA_W-1:0] CTRL_B_WMASK = 8'hc0;
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
   // Soft reset hold time, least time rounds up
   localparam int CLK_MHZ = 40;
   localparam int HOLD_NS = 10000;
   localparam logic [CNT_W-1:0] HOLD_CYCLES =
      CNT_W'((HOLD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   // Soft reset sequencer states
   typedef enum logic [2:0] {
      SR_IDLE = 3'b001,
      SR_COUNT = 3'b010,
      SR_RESET = 3'b100
   } soft_reset_state_t;
endpackage
`default_nettype wire

// ==== gc_link_if.sv ====
// Carrier between the global control top and its two helper modules
`timescale 1ns/1ps
`default_nettype none
interface gc_link_if;
   logic ce;
   logic rst;
   logic srst_req;
   logic device_reset;
   logic hold_counting;
   logic [line_global_pkg::NUM_CH-1:0] events;
   logic [line_global_pkg::NUM_CH-1:0] clr;
   logic [line_global_pkg::NUM_CH-1:0] mask;
   logic [line_global_pkg::NUM_CH-1:0] status;
   logic gate;
   logic irq;
   modport timer_mp (input ce, rst, srst_req,
                     output device_reset, hold_counting);
   modport irq_mp (input ce, rst, events, clr, mask, gate,
                   output status, irq);
   modport ctrl_mp (output ce, rst, srst_req, events, clr, mask, gate,
                    input device_reset, hold_counting, status, irq);
endinterface
`default_nettype wire

// ==== soft_reset_timer.sv ====
// Soft reset hold timer and device reset sequencer
`timescale 1ns/1ps
`default_nettype none
module soft_reset_timer (
   input wire logic clk_in,
   gc_link_if.timer_mp link
);
   typedef struct packed {
      line_global_pkg::soft_reset_state_t state_ff;
      logic [line_global_pkg::CNT_W-1:0] cnt_ff;
   } timer_state_t;

   timer_state_t st;
   timer_state_t nxt_st;

   // Count the hold, then stay in reset until the bit drops
   always_comb begin
      nxt_st = st;
      case (st.state_ff)
         line_global_pkg::SR_IDLE: begin
            if (link.srst_req) begin
               nxt_st.state_ff = line_global_pkg::SR_COUNT;
               nxt_st.cnt_ff = line_global_pkg::CNT_ONE;
            end
         end
         line_global_pkg::SR_COUNT: begin
            if (!link.srst_req) begin
               nxt_st.state_ff = line_global_pkg::SR_IDLE;
               nxt_st.cnt_ff = line_global_pkg::CNT_ZERO;
            end else if (st.cnt_ff > line_global_pkg::HOLD_CYCLES) begin
               nxt_st.state_ff = line_global_pkg::SR_RESET;
            end else begin
               nxt_st.cnt_ff = st.cnt_ff + line_global_pkg::CNT_ONE;
            end
         end
         line_global_pkg::SR_RESET: begin
            if (!link.srst_req) begin
               nxt_st.state_ff = line_global_pkg::SR_IDLE;
               nxt_st.cnt_ff = line_global_pkg::CNT_ZERO;
            end
         end
         default: begin
            nxt_st.state_ff = line_global_pkg::SR_IDLE;
            nxt_st.cnt_ff = line_global_pkg::CNT_ZERO;
         end
      endcase
   end

   // State register with clock enable
   always_ff @(posedge clk_in) begin
      if (link.rst) begin
         st.state_ff <= line_global_pkg::SR_IDLE;
         st.cnt_ff <= line_global_pkg::CNT_ZERO;
      end else if (link.ce) begin
         st <= nxt_st;
      end
   end

   assign link.device_reset = (st.state_ff == line_global_pkg::SR_RESET);
   assign link.hold_counting = (st.state_ff == line_global_pkg::SR_COUNT);
endmodule // soft_reset_timer
`default_nettype wire

// ==== irq_gate.sv ====
// Sticky interrupt status with mask and global gate
`timescale 1ns/1ps
`default_nettype none
module irq_gate (
   input wire logic clk_in,
   gc_link_if.irq_mp link
);
   typedef struct packed {
      logic [line_global_pkg::NUM_CH-1:0] status_ff;
   } irq_state_t;

   irq_state_t st;
   irq_state_t nxt_st;

   // Set wins over a clear in the same cycle
   always_comb begin
      nxt_st = st;
      nxt_st.status_ff = (st.status_ff & ~link.clr) | link.events;
   end

   always_ff @(posedge clk_in) begin
      if (link.rst) begin
         st.status_ff <= '0;
      end else if (link.ce) begin
         st <= nxt_st;
      end
   end

   assign link.status = st.status_ff;
   // Pin only with gate open and source enabled
   assign link.irq = link.gate & (|(st.status_ff & link.mask));
endmodule // irq_gate
`default_nettype wire

// ==== line_global_control.sv ====
// Global control register bank of the line interface unit
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module line_global_control (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   input wire logic [line_global_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [line_global_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [line_global_pkg::DATA_W-1:0] reg_rdata_out,
   input wire logic [line_global_pkg::NUM_CH-1:0] src_event_in,
   input wire logic [line_global_pkg::NUM_CH*line_global_pkg::SHAPE_W-1:0]
      tx_shape_sel_in,
   input wire logic [line_global_pkg::NUM_CH*line_global_pkg::EQ_W-1:0]
      equalizer_control_in,
   output logic irq_out,
   output logic device_reset_out,
   output logic [line_global_pkg::NUM_CH-1:0] tx_sync_waveform_out,
   output logic [line_global_pkg::NUM_CH*line_global_pkg::SHAPE_W-1:0]
      tx_shape_sel_out,
   output logic [line_global_pkg::NUM_CH-1:0] rx_sync_waveform_out,
   output logic [line_global_pkg::NUM_CH*line_global_pkg::EQ_W-1:0]
      equalizer_control_out
);
   localparam int NCH = line_global_pkg::NUM_CH;
   localparam int SW = line_global_pkg::SHAPE_W;
   localparam int EW = line_global_pkg::EQ_W;
   localparam int DW = line_global_pkg::DATA_W;

   // Address match, used by every register decode
   function automatic logic reg_hit(
      input logic [line_global_pkg::ADDR_W-1:0] addr,
      input logic [line_global_pkg::ADDR_W-1:0] off
   );
      reg_hit = (addr == off);
   endfunction

   // Merge writable bits of a write into a stored value
   function automatic logic [line_global_pkg::DATA_W-1:0] merge_bits(
      input logic [line_global_pkg::DATA_W-1:0] old_val,
      input logic [line_global_pkg::DATA_W-1:0] new_val,
      input logic [line_global_pkg::DATA_W-1:0] wmask
   );
      merge_bits = (old_val & ~wmask) | (new_val & wmask);
   endfunction

   // All state of the top in one record
   typedef struct packed {
      logic [DW-1:0] ctrl_a_ff;
      logic [DW-1:0] ctrl_b_ff;
      logic [DW-1:0] mask_ff;
      logic [DW-1:0] rdata_ff;
      logic [NCH-1:0] tx_sync_ff;
      logic [NCH*SW-1:0] tx_shape_ff;
      logic [NCH-1:0] rx_sync_ff;
      logic [NCH*EW-1:0] eq_ff;
   } top_state_t;

   top_state_t st;
   top_state_t nxt_st;

   gc_link_if link ();

   // Per-channel path settings after the global overrides
   logic [NCH-1:0] chan_tx_sync;
   logic [NCH*SW-1:0] chan_tx_shape;
   logic [NCH-1:0] chan_rx_sync;
   logic [NCH*EW-1:0] chan_eq;

   // Decoded strobes
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_status;
   logic wr_mask;

   // Global bits seen by the helpers and the channel logic
   logic gate_bit;
   logic srst_bit;
   logic tx_sync_bit;
   logic rx_sync_bit;

   // Read data for the addressed register
   logic [DW-1:0] rd_mux;

   // Write decode
   always_comb begin
      wr_ctrl_a = reg_wr_in & reg_hit(reg_addr_in,
                                      line_global_pkg::OFF_CTRL_A);
      wr_ctrl_b = reg_wr_in & reg_hit(reg_addr_in,
                                      line_global_pkg::OFF_CTRL_B);
      wr_status = reg_wr_in & reg_hit(reg_addr_in,
                                      line_global_pkg::OFF_IRQ_STATUS);
      wr_mask = reg_wr_in & reg_hit(reg_addr_in,
                                    line_global_pkg::OFF_IRQ_MASK);
   end

   // Named views of the global control bits
   assign gate_bit = st.ctrl_a_ff[line_global_pkg::BIT_IRQ_GATE];
   assign srst_bit = st.ctrl_a_ff[line_global_pkg::BIT_SOFT_RESET];
   assign tx_sync_bit = st.ctrl_b_ff[line_global_pkg::BIT_TX_SYNC];
   assign rx_sync_bit = st.ctrl_b_ff[line_global_pkg::BIT_RX_SYNC];

   // Helper wiring through the carrier
   assign link.ce = ce_in;
   assign link.rst = sys_rst_in;
   assign link.srst_req = srst_bit;
   assign link.gate = gate_bit;
   assign link.mask = st.mask_ff[NCH-1:0];
   // Sources are held quiet while the device sits in soft reset
   assign link.events = src_event_in & {NCH{~link.device_reset}};
   assign link.clr = wr_status ? reg_wdata_in[NCH-1:0] : '0;

   // Hold timer for the soft reset request
   soft_reset_timer u_timer (
      .clk_in (clk_in),
      .link (link.timer_mp)
   );

   // Sticky source status and the interrupt pin
   irq_gate u_irq (
      .clk_in (clk_in),
      .link (link.irq_mp)
   );

   // Channel path selection, one copy per channel
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
         // Transmit sync mode beats the channel's own shape choice
         always_comb begin
            chan_tx_sync[ch] = tx_sync_bit;
            if (tx_sync_bit) begin
               chan_tx_shape[ch*SW +: SW] = '0;
            end else begin
               chan_tx_shape[ch*SW +: SW] = tx_shape_sel_in[ch*SW +: SW];
            end
         end
         // Receive recovery follows sync mode or the equalizer field
         always_comb begin
            chan_rx_sync[ch] = rx_sync_bit;
            if (rx_sync_bit) begin
               chan_eq[ch*EW +: EW] = '0;
            end else begin
               chan_eq[ch*EW +: EW] = equalizer_control_in[ch*EW +: EW];
            end
         end
      end
   endgenerate

   // Read multiplexer, unmapped offsets read zero
   always_comb begin
      rd_mux = line_global_pkg::READ_ZERO;
      if (reg_hit(reg_addr_in, line_global_pkg::OFF_CTRL_A)) begin
         rd_mux = st.ctrl_a_ff;
      end else if (reg_hit(reg_addr_in, line_global_pkg::OFF_CTRL_B)) begin
         rd_mux = st.ctrl_b_ff;
      end else if (reg_hit(reg_addr_in,
                           line_global_pkg::OFF_IRQ_STATUS)) begin
         rd_mux = DW'(link.status);
      end else if (reg_hit(reg_addr_in, line_global_pkg::OFF_IRQ_MASK)) begin
         rd_mux = st.mask_ff;
      end else if (reg_hit(reg_addr_in, line_global_pkg::OFF_STATE)) begin
         rd_mux[line_global_pkg::BIT_RESET_ACTIVE] = link.device_reset;
         rd_mux[line_global_pkg::BIT_HOLD_COUNTING] = link.hold_counting;
      end
   end

   // Next state of the register bank and the channel outputs
   always_comb begin
      nxt_st = st;
      // Register bits survive the soft reset; only writes change them
      if (wr_ctrl_a) begin
         nxt_st.ctrl_a_ff = merge_bits(st.ctrl_a_ff, reg_wdata_in,
                                       line_global_pkg::CTRL_A_WMASK);
      end
      if (wr_ctrl_b) begin
         nxt_st.ctrl_b_ff = merge_bits(st.ctrl_b_ff, reg_wdata_in,
                                       line_global_pkg::CTRL_B_WMASK);
      end
      if (wr_mask) begin
         nxt_st.mask_ff = reg_wdata_in;
      end
      // Read data stand only in the cycle after the strobe
      if (reg_rd_in) begin
         nxt_st.rdata_ff = rd_mux;
      end else begin
         nxt_st.rdata_ff = line_global_pkg::READ_ZERO;
      end
      // Channel settings, returned to defaults while in soft reset
      if (link.device_reset) begin
         nxt_st.tx_sync_ff = '0;
         nxt_st.tx_shape_ff = '0;
         nxt_st.rx_sync_ff = '0;
         nxt_st.eq_ff = '0;
      end else begin
         nxt_st.tx_sync_ff = chan_tx_sync;
         nxt_st.tx_shape_ff = chan_tx_shape;
         nxt_st.rx_sync_ff = chan_rx_sync;
         nxt_st.eq_ff = chan_eq;
      end
   end

   // State register: synchronous reset, frozen while enable is low
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st.ctrl_a_ff <= line_global_pkg::REG_RESET;
         st.ctrl_b_ff <= line_global_pkg::REG_RESET;
         st.mask_ff <= line_global_pkg::REG_RESET;
         st.rdata_ff <= line_global_pkg::READ_ZERO;
         st.tx_sync_ff <= '0;
         st.tx_shape_ff <= '0;
         st.rx_sync_ff <= '0;
         st.eq_ff <= '0;
      end else if (ce_in) begin
         st <= nxt_st;
      end
   end

   // Outputs
   assign reg_rdata_out = st.rdata_ff;
   assign irq_out = link.irq;
   assign device_reset_out = link.device_reset;
   assign tx_sync_waveform_out = st.tx_sync_ff;
   assign tx_shape_sel_out = st.tx_shape_ff;
   assign rx_sync_waveform_out = st.rx_sync_ff;
   assign equalizer_control_out = st.eq_ff;
endmodule // line_global_control
`default_nettype wire

// ==== line_global_control_properties.sv ====
// Port checker of the line unit global control block
`timescale 1ns/1ps
`default_nettype none
module line_global_control_properties (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] src_event_in,
   input wire logic [23:0] tx_shape_sel_in,
   input wire logic [39:0] equalizer_control_in,
   input wire logic irq_out,
   input wire logic device_reset_out,
   input wire logic [7:0] tx_sync_waveform_out,
   input wire logic [23:0] tx_shape_sel_out,
   input wire logic [7:0] rx_sync_waveform_out,
   input wire logic [39:0] equalizer_control_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   logic gate_ff, srst_ff, tx_ff, rx_ff, wr_a, wr_b, wr_m;
   logic [7:0] mask_ff;
   logic [8:0] hold_ff;
   assign wr_a = reg_wr_in && reg_addr_in == 8'h00;
   assign wr_b = reg_wr_in && reg_addr_in == 8'h01;
   assign wr_m = reg_wr_in && reg_addr_in == 8'h03;
   // Shadows of the control bits and the soft reset hold count
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         {gate_ff, srst_ff, tx_ff, rx_ff} <= 4'h0;
         mask_ff <= 8'h00;
         hold_ff <= 9'h000;
      end else if (ce_in) begin
         if (wr_a) {gate_ff, srst_ff} <= reg_wdata_in[1:0];
         if (wr_b) {tx_ff, rx_ff} <= reg_wdata_in[7:6];
         if (wr_m) mask_ff <= reg_wdata_in;
         hold_ff <= srst_ff ? hold_ff + 9'(hold_ff != 9'h1ff) : 9'h000;
      end
   end
   property p_irq_gated; !gate_ff |-> !irq_out; endproperty
   a_irq_gated: assert property (p_irq_gated)
      else $error("interrupt while gate off");
   property p_irq_cause; irq_out |-> gate_ff && mask_ff != 8'h00; endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt without enabled source");
   property p_irq_event;
      $past(ce_in && !device_reset_out) && gate_ff &&
         ($past(src_event_in) & mask_ff) != 8'h00 |-> irq_out;
   endproperty
   a_irq_event: assert property (p_irq_event)
      else $error("enabled event gave no interrupt");
   property p_rst_early;
      device_reset_out && srst_ff |-> hold_ff > 9'h190;
   endproperty
   a_rst_early: assert property (p_rst_early)
      else $error("device reset before hold time");
   property p_rst_start; hold_ff == 9'h195 |-> device_reset_out; endproperty
   a_rst_start: assert property (p_rst_start)
      else $error("device reset missing after hold");
   property p_rst_end; $fell(srst_ff) |-> ##2 !device_reset_out; endproperty
   a_rst_end: assert property (p_rst_end)
      else $error("device reset not released");
   property p_tx_path;
      $past(ce_in) && !$past(sys_rst_in) && !device_reset_out &&
         !$past(device_reset_out) |-> tx_sync_waveform_out == {8{$past(tx_ff)}}
         && ($past(tx_ff) || tx_shape_sel_out == $past(tx_shape_sel_in));
   endproperty
   a_tx_path: assert property (p_tx_path)
      else $error("transmit waveform select wrong");
   property p_tx_over; tx_sync_waveform_out[0] |-> tx_shape_sel_out == 24'h0;
   endproperty
   a_tx_over: assert property (p_tx_over)
      else $error("shape not overridden");
   property p_rx_path;
      $past(ce_in) && !$past(sys_rst_in) && !device_reset_out &&
         !$past(device_reset_out) |-> rx_sync_waveform_out == {8{$past(rx_ff)}}
         && ($past(rx_ff) || equalizer_control_out ==
         $past(equalizer_control_in));
   endproperty
   a_rx_path: assert property (p_rx_path)
      else $error("receive mode select wrong");
endmodule // line_global_control_properties
bind line_global_control line_global_control_properties chk_i (.clk_in,
   .sys_rst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .src_event_in,
   .tx_shape_sel_in, .equalizer_control_in, .irq_out, .device_reset_out,
   .tx_sync_waveform_out, .tx_shape_sel_out, .rx_sync_waveform_out,
   .equalizer_control_out);
`default_nettype wire

// ==== line_global_control_test.sv ====
// Self-checking bench of the line unit global control block
`timescale 1ns/1ps
`default_nettype none
module line_global_control_test;
   localparam logic [7:0] CA = line_global_pkg::OFF_CTRL_A;
   localparam logic [7:0] CB = line_global_pkg::OFF_CTRL_B;
   localparam logic [7:0] IS = line_global_pkg::OFF_IRQ_STATUS;
   localparam logic [7:0] IM = line_global_pkg::OFF_IRQ_MASK;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, ev = 8'h00;
   logic [23:0] shp_i = 24'h12_3456;
   logic [39:0] eq_i = 40'h12_3456_789a;
   logic [7:0] rdata, tx_o, rx_o;
   logic [23:0] shp_o;
   logic [39:0] eq_o;
   logic irq, dev;
   int failures = 0;
   int n_tests = 0;
   int cyc = 0;
   always #12.5 clk_in = ~clk_in;
   line_global_control line_global_control_i (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .ce_in(ce_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .src_event_in(ev), .tx_shape_sel_in(shp_i),
      .equalizer_control_in(eq_i), .irq_out(irq), .device_reset_out(dev),
      .tx_sync_waveform_out(tx_o), .tx_shape_sel_out(shp_o),
      .rx_sync_waveform_out(rx_o), .equalizer_control_out(eq_o));
   // Compare and count
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle register write
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
      #1;
   endtask
   // Read, data checked in the following cycle
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // One-cycle event pulse
   task automatic pulse(input logic [7:0] e);
      @(posedge clk_in);
      ev <= e;
      @(posedge clk_in);
      ev <= 8'h00;
      #1;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rdc(CA, 8'h00);
      @(posedge clk_in);
      #1 chk(rdata, 8'h00);
      rdc(CB, 8'h00);
      rdc(IS, 8'h00);
      rdc(8'h05, 8'h00);
      chk({irq, dev, tx_o, rx_o}, 40'h0);
      wrr(CA, 8'hfe);
      rdc(CA, 8'h02);
      wrr(CB, 8'hff);
      rdc(CB, 8'hc0);
      chk({tx_o, rx_o, shp_o}, {16'hffff, 24'h0});
      wrr(CB, 8'h00);
      repeat (2) @(posedge clk_in);
      #1 chk({tx_o, shp_o}, {8'h00, shp_i});
      chk({rx_o, eq_o}, {8'h00, eq_i});
      wrr(CA, 8'h00);
      wrr(IM, 8'hff);
      pulse(8'h08);
      chk(irq, 1'b0);
      rdc(IS, 8'h08);
      wrr(CA, 8'h02);
      chk(irq, 1'b1);
      wrr(IM, 8'hf7);
      chk(irq, 1'b0);
      wrr(IM, 8'hff);
      wrr(IS, 8'h08);
      chk(irq, 1'b0);
      @(posedge clk_in);
      ce_in <= 1'b0;
      wrr(IM, 8'h00);
      @(posedge clk_in);
      ce_in <= 1'b1;
      rdc(IM, 8'hff);
      wrr(CB, 8'hc0);
      wrr(CA, 8'h03);
      repeat (100) @(posedge clk_in);
      wrr(CA, 8'h02);
      repeat (450) @(posedge clk_in);
      #1 chk(dev, 1'b0);
      wrr(CA, 8'h03);
      repeat (398) @(posedge clk_in);
      rdc(line_global_pkg::OFF_STATE, 8'h02);
      chk(dev, 1'b0);
      @(posedge clk_in);
      #1 chk(dev, 1'b0);
      @(posedge clk_in);
      #1 chk(dev, 1'b1);
      pulse(8'h01);
      chk({tx_o, rx_o}, 16'h0000);
      rdc(IS, 8'h00);
      rdc(CB, 8'hc0);
      rdc(IM, 8'hff);
      rdc(CA, 8'h03);
      rdc(line_global_pkg::OFF_STATE, 8'h01);
      wrr(CA, 8'h02);
      repeat (2) @(posedge clk_in);
      #1 chk({dev, tx_o}, {1'b0, 8'hff});
      // Reset again in mid-run, all global bits back to zero
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rdc(CA, 8'h00);
      rdc(CB, 8'h00);
      rdc(IM, 8'h00);
      chk({irq, dev, tx_o}, 10'h000);
      end_of_test();
   end
endmodule // line_global_control_test
`default_nettype wire
